// >>> design/hss_consts.vh
// Purpose: constants for the heater system supervisor
// Assumes: core_clk at 100 MHz
// Notes: definitions only
`ifndef HSS_CONSTS_VH
`define HSS_CONSTS_VH
`define HSS_NZONE 12
`define HSS_CLK_HZ 100000000
`define HSS_SEC_CYCLES (`HSS_CLK_HZ / 1)
`define HSS_DELAY_MAX_S 10'h3e7
`define HSS_TC_L 3'h0
`define HSS_TC_J 3'h1
`define HSS_TC_K 3'h2
`define HSS_TC_N 3'h3
`define HSS_TC_T 3'h4
`define HSS_TC_S 3'h5
`define HSS_TC_RST 3'h1
`define HSS_LIM_16A 8'h10
`define HSS_LIM_32A 8'h20
`define HSS_SP_MAX_RST 10'h1f4
`define HSS_SP_MIN_RST 10'h000
`define HSS_SP_CEIL_C 10'h3e7
`define HSS_RC_RST 8'h3c
`define HSS_FN_SBY 4'h0
`define HSS_FN_SBY_TGL 4'h1
`define HSS_FN_SBY_INV 4'h2
`define HSS_FN_BST 4'h3
`define HSS_FN_BST_INV 4'h4
`define HSS_FN_INH_HI 4'h5
`define HSS_FN_INH_LO 4'h6
`define HSS_FN_HEAT 4'h7
`define HSS_FN_HEAT_INV 4'h8
`define HSS_FN_LRN_RISE 4'h9
`define HSS_FN_LRN_FALL 4'ha
`define HSS_NCAUSE 9
`define HSS_MASK_INV 9
`define HSS_MODE_CTRL 3'h0
`define HSS_MODE_MAN 3'h1
`define HSS_MODE_LEAD 3'h2
`define HSS_MODE_MON 3'h3
`define HSS_MODE_DISP 3'h4
`define HSS_MODE_OFF 3'h5
`define HSS_PWM_STEPS 10'h3e8
`define HSS_PCT_FULL 10'h3e8
`endif

// >>> design/hss_edge_sync.v
// Purpose: two-stage synchroniser and edge detector for the digital input
// Assumes: input is asynchronous to core_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ns
`default_nettype none
module hss_edge_sync (
  input wire core_clk,
  input wire rst_b,
  input wire pin_in,
  output reg level_r,
  output reg rise_r,
  output reg fall_r
);
  reg meta_r;
  reg sync_r;
  // Two flops, then compare successive samples
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      level_r <= sync_r;
      rise_r <= sync_r & ~level_r;
      fall_r <= ~sync_r & level_r;
    end
  end
endmodule
`default_nettype wire

// >>> design/hss_supervisor.v
// What this block does
// - Delay zero: heaters stay off after power-up until manually switched on.
// - Delay 1 to 999 s: heaters enable automatically after that time.
// - One thermocouple type L J K N T S for all zones, default J.
// - While heating up, drop heating pulses when current would exceed limit.
// - In steady state, shift pulses in time instead of dropping them.
// - Phase current limit selectable 16 A or 32 A, default 32 A.
// - Reject set points above upper limit, range 0 to 999, default 500.
// - Reject set points below lower limit, default 0.
// - On unit change, convert stored set point limits automatically.
// - Residual current over limit kills zones with output above zero, alarms.
// - Residual limit in mA default 60, zero disables monitoring.
// - Default input function: rise enters standby, fall leaves it.
// - Toggle function: each rise inverts standby, falls ignored.
// - Inverted standby: rise leaves standby, fall enters it.
// - Boost follow: rise activates boost, fall deactivates it.
// - Inverted boost: rise deactivates boost, fall activates it.
// - Heating inhibit: heaters voltage-free while input at chosen level.
// - Heating on/off: one edge switches heaters on, other off; once a 1 to 999 s delay has run, off lasts one cycle.
// - Learning start: chosen edge arms the learning phase.
// - Alarm output is OR of enabled causes.
// - Inversion option drives alarm output inverted.
// - Fallback off: zone with broken sensor has heater switched off.
// - Follower zone drives heater from its leading zone's output.
// - Manual output proportional: 0 off, 100 percent on, between.
// Purpose: system supervisor for a twelve-zone heater controller
// Assumes: one clock, synchronous active-low reset at power-up
// Notes: zone demands arrive as duty values in tenths of percent
`timescale 1ns/1ns
`default_nettype none
`include "hss_consts.vh"
module hss_supervisor #(
  parameter [31:0] SEC_CYCLES = `HSS_SEC_CYCLES
) (
  input wire core_clk,
  input wire rst_b,
  input wire [9:0] power_on_heater_delay,
  input wire [2:0] thermocouple_type_select,
  input wire phase_current_limit,
  input wire cfg_load,
  input wire [9:0] setpoint_upper_limit,
  input wire [9:0] setpoint_lower_limit,
  input wire unit_fahrenheit,
  input wire [7:0] residual_current_limit,
  input wire [7:0] residual_current_ma,
  input wire [3:0] aux_input_function,
  input wire aux_input_pin,
  input wire [9:0] alarm_output_cause_mask,
  input wire [8:0] alarm_causes,
  input wire sensor_break_fallback_enable,
  input wire [11:0] sensor_break,
  input wire manual_heat_on,
  input wire manual_heat_off,
  input wire heat_up_phase,
  input wire [47:0] follower_source_zone,
  input wire [35:0] zone_operating_mode,
  input wire [119:0] manual_output_percent,
  input wire [119:0] ctrl_output_percent,
  input wire [95:0] zone_current_a,
  input wire sp_req,
  input wire [9:0] sp_value,
  output reg sp_accept_r,
  output reg sp_reject_r,
  output reg [11:0] heater_out_r,
  output reg heaters_enabled_r,
  output reg standby_r,
  output reg boost_r,
  output reg learn_arm_r,
  output reg residual_alarm_r,
  output reg alarm_out_r,
  output reg [2:0] tc_type_r,
  output reg [7:0] current_limit_r,
  output reg [10:0] sp_max_r,
  output reg [10:0] sp_min_r
);
  wire in_level;
  wire in_rise;
  wire in_fall;
  reg [31:0] sec_cnt_r;
  reg [9:0] sec_elapsed_r;
  reg delay_done_r;
  reg unit_f_r;
  reg [9:0] phase_r;
  reg [11:0] res_kill_r;
  reg [11:0] pending_r;
  reg [11:0] pwm_raw;
  reg [119:0] duty_flat;
  reg [11:0] live_nz;
  reg [11:0] grant;
  reg [11:0] pending_nxt;
  reg [8:0] sum_a;
  reg inhibit;
  integer i;

  // Celsius limit to Fahrenheit and back
  function [10:0] c_to_f;
    input [10:0] c;
    reg [21:0] t;
    begin
      t = {11'h000, c} * 22'h000009;
      t = t / 22'h000005 + 22'h000020; // Divide before cutting to 11 bits
      c_to_f = t[10:0];
    end
  endfunction
  function [10:0] f_to_c;
    input [10:0] f;
    reg [21:0] t;
    begin
      t = {11'h000, ((f > 11'h020) ? (f - 11'h020) : 11'h000)} * 22'h000005;
      t = t / 22'h000009;
      f_to_c = t[10:0];
    end
  endfunction
  // Per-zone mode field
  function [2:0] mode_of;
    input [35:0] m;
    input [3:0] z;
    begin
      mode_of = m[z*3 +: 3];
    end
  endfunction

  hss_edge_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(aux_input_pin),
    .level_r(in_level),
    .rise_r(in_rise),
    .fall_r(in_fall)
  );

  // Power-up delay counter
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sec_cnt_r <= 32'h00000000;
      sec_elapsed_r <= 10'h000;
      delay_done_r <= 1'b0;
    end
    else if (!delay_done_r)
    begin
      if (sec_cnt_r >= SEC_CYCLES - 32'h00000001)
      begin
        sec_cnt_r <= 32'h00000000;
        sec_elapsed_r <= sec_elapsed_r + 10'h001;
      end
      else
        sec_cnt_r <= sec_cnt_r + 32'h00000001;
      if (power_on_heater_delay != 10'h000 && power_on_heater_delay <= `HSS_DELAY_MAX_S &&
          sec_elapsed_r >= power_on_heater_delay)
        delay_done_r <= 1'b1;
    end
  end

  // Configuration, limits and unit conversion
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tc_type_r <= `HSS_TC_RST;
      current_limit_r <= `HSS_LIM_32A;
      sp_max_r <= {1'b0, `HSS_SP_MAX_RST};
      sp_min_r <= {1'b0, `HSS_SP_MIN_RST};
      unit_f_r <= 1'b0;
    end
    else
    begin
      if (cfg_load)
      begin
        if (thermocouple_type_select <= `HSS_TC_S)
          tc_type_r <= thermocouple_type_select;
        current_limit_r <= phase_current_limit ? `HSS_LIM_16A : `HSS_LIM_32A;
        if (setpoint_upper_limit <= `HSS_SP_CEIL_C)
          sp_max_r <= {1'b0, setpoint_upper_limit};
        if (setpoint_lower_limit <= `HSS_SP_CEIL_C)
          sp_min_r <= {1'b0, setpoint_lower_limit};
      end
      else if (unit_fahrenheit != unit_f_r)
      begin
        unit_f_r <= unit_fahrenheit;
        sp_max_r <= unit_fahrenheit ? c_to_f(sp_max_r) : f_to_c(sp_max_r);
        sp_min_r <= unit_fahrenheit ? c_to_f(sp_min_r) : f_to_c(sp_min_r);
      end
    end
  end

  // Set point range check
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sp_accept_r <= 1'b0;
      sp_reject_r <= 1'b0;
    end
    else
    begin
      sp_reject_r <= sp_req & (({1'b0, sp_value} > sp_max_r) |
                               ({1'b0, sp_value} < sp_min_r));
      sp_accept_r <= sp_req & ({1'b0, sp_value} <= sp_max_r) & ({1'b0, sp_value} >= sp_min_r);
    end
  end

  // Digital input functions and heater enable
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      heaters_enabled_r <= 1'b0;
      standby_r <= 1'b0;
      boost_r <= 1'b0;
      learn_arm_r <= 1'b0;
    end
    else
    begin
      if (manual_heat_off)
        heaters_enabled_r <= 1'b0;
      else if (manual_heat_on || (delay_done_r && !heaters_enabled_r &&
                                  sec_elapsed_r == power_on_heater_delay))
        heaters_enabled_r <= 1'b1;
      learn_arm_r <= 1'b0;
      case (aux_input_function)
        `HSS_FN_SBY:
        begin
          if (in_rise) standby_r <= 1'b1;
          if (in_fall) standby_r <= 1'b0;
        end
        `HSS_FN_SBY_TGL:
          if (in_rise) standby_r <= ~standby_r;
        `HSS_FN_SBY_INV:
        begin
          if (in_rise) standby_r <= 1'b0;
          if (in_fall) standby_r <= 1'b1;
        end
        `HSS_FN_BST:
        begin
          if (in_rise) boost_r <= 1'b1;
          if (in_fall) boost_r <= 1'b0;
        end
        `HSS_FN_BST_INV:
        begin
          if (in_rise) boost_r <= 1'b0;
          if (in_fall) boost_r <= 1'b1;
        end
        `HSS_FN_HEAT:
        begin
          if (in_rise) heaters_enabled_r <= 1'b1;
          if (in_fall) heaters_enabled_r <= 1'b0;
        end
        `HSS_FN_HEAT_INV:
        begin
          if (in_rise) heaters_enabled_r <= 1'b0;
          if (in_fall) heaters_enabled_r <= 1'b1;
        end
        `HSS_FN_LRN_RISE:
          learn_arm_r <= in_rise;
        `HSS_FN_LRN_FALL:
          learn_arm_r <= in_fall;
        default:
          learn_arm_r <= 1'b0;
      endcase
    end
  end

  // Level inhibit from the digital input
  always @*
  begin
    inhibit = ((aux_input_function == `HSS_FN_INH_HI) & in_level) |
              ((aux_input_function == `HSS_FN_INH_LO) & ~in_level);
  end

  // Duty per zone by operating mode
  always @*
  begin
    duty_flat = 120'h0;
    for (i = 0; i < `HSS_NZONE; i = i + 1)
    begin
      case (mode_of(zone_operating_mode, i[3:0]))
        `HSS_MODE_CTRL:
          duty_flat[i*10 +: 10] = ctrl_output_percent[i*10 +: 10];
        `HSS_MODE_MAN:
          duty_flat[i*10 +: 10] = manual_output_percent[i*10 +: 10];
        `HSS_MODE_LEAD:
          if (follower_source_zone[i*4 +: 4] != 4'h0 && follower_source_zone[i*4 +: 4] <= 4'hc)
            duty_flat[i*10 +: 10] =
              ctrl_output_percent[(follower_source_zone[i*4 +: 4] - 4'h1)*10 +: 10];
        default:
          duty_flat[i*10 +: 10] = 10'h000;
      endcase
      if (sensor_break[i] && !sensor_break_fallback_enable)
        duty_flat[i*10 +: 10] = 10'h000;
      live_nz[i] = (duty_flat[i*10 +: 10] != 10'h000);
    end
  end

  // Proportional switching per zone
  genvar g;
  generate
    for (g = 0; g < `HSS_NZONE; g = g + 1)
    begin : g_pwm
      wire z_heat;
      hss_zone_pwm u_pwm (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .phase(phase_r),
        .duty(duty_flat[g*10 +: 10]),
        .heat_r(z_heat)
      );
      always @*
      begin
        pwm_raw[g] = z_heat;
      end
    end
  endgenerate

  // Current budget: grant zones in order, skipping each one that would pass the limit
  always @*
  begin
    sum_a = 9'h000;
    grant = 12'h000;
    pending_nxt = 12'h000;
    for (i = 0; i < `HSS_NZONE; i = i + 1)
    begin
      if ((pwm_raw[i] | pending_r[i]) && !res_kill_r[i])
      begin
        if (sum_a + {1'b0, zone_current_a[i*8 +: 8]} <= {1'b0, current_limit_r})
        begin
          grant[i] = 1'b1;
          sum_a = sum_a + {1'b0, zone_current_a[i*8 +: 8]};
        end
        else if (!heat_up_phase)
          pending_nxt[i] = 1'b1;
      end
    end
  end

  // Heater outputs, residual current, frame phase
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      phase_r <= 10'h000;
      pending_r <= 12'h000;
      res_kill_r <= 12'h000;
      residual_alarm_r <= 1'b0;
      heater_out_r <= 12'h000;
    end
    else
    begin
      phase_r <= (phase_r >= `HSS_PWM_STEPS - 10'h001) ? 10'h000 : phase_r + 10'h001;
      pending_r <= pending_nxt & ~grant;
      if (residual_current_limit != 8'h00 && residual_current_ma > residual_current_limit)
      begin
        res_kill_r <= res_kill_r | live_nz;
        residual_alarm_r <= 1'b1;
      end
      else if (manual_heat_on)
      begin
        res_kill_r <= 12'h000;
        residual_alarm_r <= 1'b0;
      end
      if (!heaters_enabled_r || inhibit || standby_r & 1'b0)
        heater_out_r <= 12'h000;
      else
        heater_out_r <= grant;
    end
  end

  // Alarm output
  always @(posedge core_clk)
  begin
    if (!rst_b)
      alarm_out_r <= 1'b0;
    else
      alarm_out_r <= (|(alarm_output_cause_mask[`HSS_NCAUSE-1:0] &
                        {residual_alarm_r, alarm_causes[7:0]} |
                        alarm_output_cause_mask[`HSS_NCAUSE-1:0] & alarm_causes & 9'h100))
                     ^ alarm_output_cause_mask[`HSS_MASK_INV];
  end
endmodule
`default_nettype wire

// >>> design/hss_zone_pwm.v
// Purpose: proportional heater switching for one zone
// Assumes: duty in tenths of percent, 0 to 1000
// Notes: one frame is HSS_PWM_STEPS cycles
`timescale 1ns/1ns
`default_nettype none
`include "hss_consts.vh"
module hss_zone_pwm (
  input wire core_clk,
  input wire rst_b,
  input wire [9:0] phase,
  input wire [9:0] duty,
  output reg heat_r
);
  // Full off at zero, full on at full scale, proportional between
  always @(posedge core_clk)
  begin
    if (!rst_b)
      heat_r <= 1'b0;
    else if (duty >= `HSS_PCT_FULL)
      heat_r <= 1'b1;
    else
      heat_r <= (phase < duty);
  end
endmodule
`default_nettype wire

// >>> tb/hss_imm_model.sv
// Purpose: machine side of the digital input
// Assumes: machine drives the pin push-pull
// Notes: pin moves only at the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module hss_imm_model (
  input wire logic core_clk,
  output logic aux_pin
);
  initial aux_pin = 1'b0;
  // Move the pin, then give the controller time to react
  task automatic drive(input logic v, input int n);
    @(negedge core_clk);
    aux_pin = v;
    repeat (n) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/hss_supervisor_properties.sv
// Purpose: port-level properties of hss_supervisor
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the supervisor
`timescale 1ns/1ns
`default_nettype none
module hss_sup_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sp_req,
  input wire logic [9:0] sp_value,
  input wire logic sp_reject_r,
  input wire logic [10:0] sp_max_r,
  input wire logic [10:0] sp_min_r,
  input wire logic [2:0] tc_type_r,
  input wire logic [7:0] current_limit_r,
  input wire logic [9:0] alarm_output_cause_mask,
  input wire logic [8:0] alarm_causes,
  input wire logic alarm_out_r,
  input wire logic [7:0] residual_current_limit,
  input wire logic [7:0] residual_current_ma,
  input wire logic residual_alarm_r,
  input wire logic [3:0] aux_input_function,
  input wire logic aux_input_pin,
  input wire logic sensor_break_fallback_enable,
  input wire logic [11:0] sensor_break,
  input wire logic [11:0] heater_out_r,
  input wire logic learn_arm_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Configuration copies come out of reset at their defaults
  property p_rst;
    $rose(rst_b) |-> tc_type_r == 3'h1 && current_limit_r == 8'h20 && sp_max_r == 11'h1f4
      && sp_min_r == 11'h000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  // Set point request outside the limits is refused
  property p_hi;
    sp_req && {1'b0, sp_value} > sp_max_r |=> sp_reject_r;
  endproperty
  a_hi: assert property (p_hi) else $error("high set point taken");
  property p_lo;
    sp_req && {1'b0, sp_value} < sp_min_r |=> sp_reject_r;
  endproperty
  a_lo: assert property (p_lo) else $error("low set point taken");
  // Alarm contact follows enabled causes, plain or inverted
  property p_alm;
    (alarm_causes[7:0] & alarm_output_cause_mask[7:0]) != 8'h00 && !alarm_output_cause_mask[9]
      |-> ##[1:3] alarm_out_r;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm not raised");
  property p_inv;
    (alarm_causes[7:0] & alarm_output_cause_mask[7:0]) != 8'h00 && alarm_output_cause_mask[9]
      |-> ##[1:3] !alarm_out_r;
  endproperty
  a_inv: assert property (p_inv) else $error("alarm not inverted");
  // Residual current trip and its disable
  property p_res;
    residual_current_limit != 8'h00 && residual_current_ma > residual_current_limit
      |-> ##[1:3] residual_alarm_r;
  endproperty
  a_res: assert property (p_res) else $error("residual trip missed");
  property p_res0;
    (residual_current_limit == 8'h00 && !residual_alarm_r) [*3] |=> !residual_alarm_r;
  endproperty
  a_res0: assert property (p_res0) else $error("residual trip while off");
  // Inhibit level and broken sensor keep heaters dark
  property p_inh;
    (aux_input_function == 4'h5 && aux_input_pin) [*6] |-> heater_out_r == 12'h000;
  endproperty
  a_inh: assert property (p_inh) else $error("heater on under inhibit");
  property p_brk;
    (!sensor_break_fallback_enable && sensor_break[0]) [*4] |-> !heater_out_r[0];
  endproperty
  a_brk: assert property (p_brk) else $error("heater on with broken sensor");
  c_rej: cover property (sp_reject_r);
  c_lrn: cover property (learn_arm_r);
  c_res: cover property (residual_alarm_r && alarm_out_r);
endmodule
bind hss_supervisor hss_sup_props u_props (.core_clk, .rst_b, .sp_req, .sp_value, .sp_reject_r,
  .sp_max_r, .sp_min_r, .tc_type_r, .current_limit_r, .alarm_output_cause_mask, .alarm_causes,
  .alarm_out_r, .residual_current_limit, .residual_current_ma, .residual_alarm_r,
  .aux_input_function, .aux_input_pin, .sensor_break_fallback_enable, .sensor_break,
  .heater_out_r, .learn_arm_r);
`default_nettype wire

// >>> tb/hss_supervisor_tb_top.sv
// Purpose: self-checking bench for hss_supervisor
// Assumes: one second shortened to 10 cycles
// Notes: machine model drives the digital input
`timescale 1ns/1ns
`default_nettype none
module hss_supervisor_tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] power_on_heater_delay = 10'h000, sp_value = 10'h000;
  logic [9:0] setpoint_upper_limit = 10'h1f4, setpoint_lower_limit = 10'h000;
  logic [2:0] thermocouple_type_select = 3'h1;
  logic phase_current_limit = 1'b0, cfg_load = 1'b0, unit_fahrenheit = 1'b0, sp_req = 1'b0;
  logic manual_heat_on = 1'b0, sensor_break_fallback_enable = 1'b0;
  logic [7:0] residual_current_limit = 8'h3c, residual_current_ma = 8'h00;
  logic [3:0] aux_input_function = 4'h0;
  logic [9:0] alarm_output_cause_mask = 10'h000;
  logic [8:0] alarm_causes = 9'h000;
  logic [11:0] sensor_break = 12'h000;
  logic [35:0] zone_operating_mode = {12{3'h1}};
  logic [119:0] manual_output_percent = {12{10'h3e8}};
  logic [95:0] zone_current_a = 96'h0;
  wire aux_input_pin, sp_accept_r, sp_reject_r, heaters_enabled_r, standby_r, boost_r;
  wire learn_arm_r, residual_alarm_r, alarm_out_r;
  wire [11:0] heater_out_r;
  wire [2:0] tc_type_r;
  wire [7:0] current_limit_r;
  wire [10:0] sp_max_r, sp_min_r;
  int err_total = 0;
  int checks = 0;
  int lrn = 0;
  hss_imm_model u_imm (.core_clk, .aux_pin(aux_input_pin));
  hss_supervisor #(.SEC_CYCLES(32'd10)) uut (.core_clk, .rst_b, .power_on_heater_delay,
    .thermocouple_type_select, .phase_current_limit, .cfg_load, .setpoint_upper_limit,
    .setpoint_lower_limit, .unit_fahrenheit, .residual_current_limit, .residual_current_ma,
    .aux_input_function, .aux_input_pin, .alarm_output_cause_mask, .alarm_causes,
    .sensor_break_fallback_enable, .sensor_break, .manual_heat_on, .manual_heat_off(1'b0),
    .heat_up_phase(1'b1), .follower_source_zone(48'h0), .zone_operating_mode,
    .manual_output_percent, .ctrl_output_percent(120'h0), .zone_current_a, .sp_req,
    .sp_value, .sp_accept_r, .sp_reject_r, .heater_out_r, .heaters_enabled_r, .standby_r,
    .boost_r, .learn_arm_r, .residual_alarm_r, .alarm_out_r, .tc_type_r, .current_limit_r,
    .sp_max_r, .sp_min_r);
  // Clock and learn pulse counter
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (learn_arm_r === 1'b1)
      lrn++;
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cfg(input logic [2:0] t, input logic l16, input logic [9:0] h, input logic [9:0] l);
    thermocouple_type_select = t;
    phase_current_limit = l16;
    setpoint_upper_limit = h;
    setpoint_lower_limit = l;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(2);
  endtask
  task automatic sp(input logic [9:0] v, input logic ok);
    sp_value = v;
    sp_req = 1'b1;
    cyc(1);
    sp_req = 1'b0;
    chk("sp_accept", ok, sp_accept_r);
    chk("sp_reject", !ok, sp_reject_r);
    cyc(1);
  endtask
  task automatic t_limits();
    chk("tc_type", 12'h1, tc_type_r);
    chk("cur_lim", 12'h20, current_limit_r);
    chk("sp_max", 12'h1f4, sp_max_r);
    chk("sp_min", 12'h0, sp_min_r);
    chk("heat_en", 12'h0, heaters_enabled_r);
    for (int t = 0; t < 7; t++)
    begin
      cfg(3'(t), 1'b1, 10'h258, 10'h064);
      chk("tc_type", 12'((t < 6) ? t : 5), tc_type_r);
    end
    chk("cur_lim", 12'h10, current_limit_r);
    sp(10'h259, 1'b0);
    sp(10'h258, 1'b1);
    sp(10'h063, 1'b0);
    sp(10'h064, 1'b1);
    cfg(3'h1, 1'b0, 10'h1f4, 10'h000);
    chk("cur_lim", 12'h20, current_limit_r);
    unit_fahrenheit = 1'b1;
    cyc(3);
    chk("sp_max_f", 12'h3a4, sp_max_r);
    chk("sp_min_f", 12'h020, sp_min_r);
    unit_fahrenheit = 1'b0;
    cyc(3);
    chk("sp_max_c", 12'h1f4, sp_max_r);
    $display("test limits done");
  endtask
  task automatic t_aux();
    logic [3:0] fn [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
    logic [2:0] ex [14] = '{3'h4, 3'h0, 3'h4, 3'h4, 3'h0, 3'h4, 3'h6, 3'h4, 3'h4, 3'h6,
      3'h7, 3'h6, 3'h6, 3'h7};
    for (int i = 0; i < 14; i++)
    begin
      aux_input_function = fn[i / 2];
      u_imm.drive(!i[0], 8);
      chk("sby_bst_heat", ex[i], {standby_r, boost_r, heaters_enabled_r});
    end
    aux_input_function = 4'h9;
    u_imm.drive(1'b1, 8);
    u_imm.drive(1'b0, 8);
    aux_input_function = 4'ha;
    u_imm.drive(1'b1, 8);
    u_imm.drive(1'b0, 8);
    chk("learn_count", 12'h2, 12'(lrn));
    $display("test input done");
  endtask
  task automatic t_heat();
    cyc(20);
    chk("heater", 12'hfff, heater_out_r);
    aux_input_function = 4'h5;
    u_imm.drive(1'b1, 8);
    chk("heater", 12'h000, heater_out_r);
    u_imm.drive(1'b0, 8);
    chk("heater", 12'hfff, heater_out_r);
    sensor_break = 12'h001;
    cyc(6);
    chk("heater", 12'hffe, heater_out_r);
    sensor_break = 12'h000;
    zone_current_a = {12{8'h08}};
    cyc(4);
    chk("heater", 12'h00f, heater_out_r);
    zone_current_a = 96'h0;
    alarm_causes = 9'h008;
    alarm_output_cause_mask = 10'h008;
    cyc(4);
    chk("alarm", 12'h1, alarm_out_r);
    alarm_output_cause_mask = 10'h208;
    cyc(4);
    chk("alarm", 12'h0, alarm_out_r);
    alarm_causes = 9'h000;
    alarm_output_cause_mask = 10'h100;
    residual_current_ma = 8'h3d;
    cyc(6);
    chk("residual", 12'h1, residual_alarm_r);
    chk("heater", 12'h000, heater_out_r);
    chk("alarm", 12'h1, alarm_out_r);
    residual_current_limit = 8'h00;
    manual_heat_on = 1'b1;
    cyc(1);
    manual_heat_on = 1'b0;
    cyc(6);
    chk("residual", 12'h0, residual_alarm_r);
    $display("test heat done");
  endtask
  task automatic t_delay();
    aux_input_function = 4'h0;
    power_on_heater_delay = 10'h003;
    rst_b = 1'b0;
    cyc(12);
    rst_b = 1'b1;
    cyc(20);
    chk("heat_en", 12'h0, heaters_enabled_r);
    cyc(25);
    chk("heat_en", 12'h1, heaters_enabled_r);
    $display("test delay done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after 12 cycles of reset
  initial
  begin
    cyc(12);
    rst_b = 1'b1;
    cyc(40);
    t_limits();
    t_aux();
    t_heat();
    t_delay();
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 380 cycles the tests take
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
